// ===== rtl/lvp_defs.svh
// Purpose: Constants for the line-out volume and analog power registers
// Assumes: 25 MHz core clock
// Notes:   Word address on the bus equals the register offset
`ifndef LVP_DEFS_SVH
`define LVP_DEFS_SVH
`define LVP_IDX_VOL      6'h2E
`define LVP_IDX_PWR      6'h30
`define LVP_IDX_STS      6'h32
`define LVP_VOL_RST      16'h0404
`define LVP_VOL_MASK     16'h1F1F
`define LVP_PWR_RST      16'h7060
`define LVP_RIGHT_HI     12
`define LVP_RIGHT_LO     8
`define LVP_LEFT_HI      4
`define LVP_LEFT_LO      0
`define LVP_B_RSVD       15
`define LVP_B_DAC_MONO   14
`define LVP_B_SIMPLE     13
`define LVP_B_STARTUP    12
`define LVP_B_CHGPMP     11
`define LVP_B_PLL        10
`define LVP_B_PRIMARY    9
`define LVP_B_OSCAMP     8
`define LVP_B_GREF       7
`define LVP_B_ADC_MONO   6
`define LVP_B_REFBIAS    5
`define LVP_B_HP         4
`define LVP_B_DAC        3
`define LVP_B_CAPLESS    2
`define LVP_B_ADC        1
`define LVP_B_LINE       0
`define LVP_CLK_NS       40
`define LVP_RAMP_MS      400
`define LVP_RAMP_CYC     ((`LVP_RAMP_MS * 1000000) / `LVP_CLK_NS)
`define LVP_RESP_OK      2'h0
`define LVP_RESP_DECERR  2'h3
`endif

// ===== rtl/lvp_pkg.sv
// Purpose: Types for the line-out volume and analog power registers
// Assumes: lvp_defs.svh holds all constants
// Notes:   One packed struct carries the whole block state
`include "lvp_defs.svh"
package lvp_pkg;
  typedef struct packed {
    logic [4:0]  atten_right;
    logic [4:0]  atten_left;
    logic [15:0] pwr;
    logic [15:0] pwr_out;
    logic        waitreq;
    logic [31:0] rdata;
    logic [1:0]  resp;
    logic [23:0] ramp_cnt;
    logic        ramp_busy;
    logic        ramp_up;
  } lvp_state_t;
endpackage

// ===== rtl/lvp_regs.sv
// Purpose: Line-out volume and analog power-control register bank
// Assumes: Avalon-MM slave with waitrequest, word addresses
// Notes:   Answer one cycle after request; ramp-down holds drivers
//
// Overview of operation
// - Right 12:8, left 4:0 volume, reset 4
// - Each code adds half dB attenuation
// - Power register holds all analog power-downs
// - Ground buffer 7, adc mono 6, bias 5
// - Dac mono at bit 14, resets mono
// - Simple core regulator bit 13, resets on
// - Startup circuitry bit 12, resets on
// - PLL enable bit 10, resets off
// - Primary core regulator bit 9, resets off
// - Ground buffer ramps; drivers held during ramp-down
// - Adc mono resets to stereo
//
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "lvp_defs.svh"
module lvp_regs
  import lvp_pkg::*;
#(
  parameter int unsigned RAMP_CYC = `LVP_RAMP_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic      [1:0]  avs_response,
  output logic      [4:0]  lineout_atten_right,
  output logic      [4:0]  lineout_atten_left,
  output logic             dac_mono_n_stereo,
  output logic             core_reg_simple_on,
  output logic             startup_circuit_on,
  output logic             charge_pump_on,
  output logic             pll_on,
  output logic             core_reg_primary_on,
  output logic             osc_amp_on,
  output logic             ground_ref_buffer_on,
  output logic             adc_stereo,
  output logic             ref_bias_current_on,
  output logic             headphone_on,
  output logic             dac_on,
  output logic             capless_hp_on,
  output logic             adc_on,
  output logic             line_driver_on,
  output logic             ramp_busy
);

  lvp_state_t s_q;
  lvp_state_t s_d;

  // Merge write data into a 16-bit register by byte lanes
  function automatic logic [15:0] lvp_merge(
    input logic [15:0] old_v,
    input logic [31:0] wdat,
    input logic [3:0]  be
  );
    logic [15:0] r;
    r = old_v;
    if (be[0]) begin
      r[7:0] = wdat[7:0];
    end
    if (be[1]) begin
      r[15:8] = wdat[15:8];
    end
    return r;
  endfunction

  // Word address matches a register offset
  function automatic logic lvp_hit(
    input logic [7:0] addr,
    input logic [5:0] idx
  );
    return addr == {2'b00, idx};
  endfunction

  logic        hit_vol;
  logic        hit_pwr;
  logic        hit_sts;
  logic        req;
  logic [15:0] vol_view;
  logic [15:0] pwr_new;

  assign hit_vol = lvp_hit(avs_address, `LVP_IDX_VOL);
  assign hit_pwr = lvp_hit(avs_address, `LVP_IDX_PWR);
  assign hit_sts = lvp_hit(avs_address, `LVP_IDX_STS);
  assign req     = avs_read | avs_write;
  // Reserved volume bits read as zero
  assign vol_view = {3'h0, s_q.atten_right, 3'h0, s_q.atten_left};
  assign pwr_new  = lvp_merge(s_q.pwr, avs_writedata, avs_byteenable);

  always_comb begin
    s_d = s_q;
    s_d.waitreq = 1'b1;
    if (req && s_q.waitreq) begin
      s_d.waitreq = 1'b0;
      s_d.resp    = `LVP_RESP_OK;
      s_d.rdata   = 32'h0000_0000;
      if (hit_vol) begin
        s_d.rdata[15:0] = vol_view;
      end else if (hit_pwr) begin
        s_d.rdata[15:0] = s_q.pwr;
      end else if (hit_sts) begin
        s_d.rdata[1:0] = {s_q.ramp_up, s_q.ramp_busy};
      end else begin
        s_d.resp = `LVP_RESP_DECERR;
      end
    end
    // Writes take effect at the edge that ends the wait
    if (avs_write && !s_q.waitreq) begin
      if (hit_vol) begin
        // Right and left codes, half dB per step
        s_d.atten_right = vol_view_w(avs_writedata, avs_byteenable,
                                     vol_view, 1'b1);
        s_d.atten_left  = vol_view_w(avs_writedata, avs_byteenable,
                                     vol_view, 1'b0);
      end else if (hit_pwr) begin
        // Every bit of the enabled bytes stored, bit 15 included
        s_d.pwr = pwr_new;
        if (pwr_new[`LVP_B_GREF] != s_q.pwr[`LVP_B_GREF]) begin
          // Ground buffer edge starts a ramp
          s_d.ramp_busy = 1'b1;
          s_d.ramp_up   = pwr_new[`LVP_B_GREF];
          s_d.ramp_cnt  = 24'(RAMP_CYC - 1);
        end
      end
    end
    if (s_q.ramp_busy && !(avs_write && !s_q.waitreq && hit_pwr &&
        pwr_new[`LVP_B_GREF] != s_q.pwr[`LVP_B_GREF])) begin
      if (s_q.ramp_cnt == 24'h00_0000) begin
        s_d.ramp_busy = 1'b0;
      end else begin
        s_d.ramp_cnt = s_q.ramp_cnt - 24'h00_0001;
      end
    end
    // Output amplifiers stay on until ramp-down ends
    s_d.pwr_out = s_d.pwr;
    if (s_d.ramp_busy && !s_d.ramp_up) begin
      s_d.pwr_out[`LVP_B_LINE]    = s_d.pwr[`LVP_B_LINE] |
                                    s_q.pwr_out[`LVP_B_LINE];
      s_d.pwr_out[`LVP_B_HP]      = s_d.pwr[`LVP_B_HP] |
                                    s_q.pwr_out[`LVP_B_HP];
      s_d.pwr_out[`LVP_B_CAPLESS] = s_d.pwr[`LVP_B_CAPLESS] |
                                    s_q.pwr_out[`LVP_B_CAPLESS];
    end
  end

  // Extract one merged volume field
  function automatic logic [4:0] vol_view_w(
    input logic [31:0] wdat,
    input logic [3:0]  be,
    input logic [15:0] cur,
    input logic        right
  );
    logic [15:0] m;
    m = lvp_merge(cur, wdat, be) & `LVP_VOL_MASK;
    if (right) begin
      return m[`LVP_RIGHT_HI:`LVP_RIGHT_LO];
    end
    return m[`LVP_LEFT_HI:`LVP_LEFT_LO];
  endfunction

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s_q.atten_right <= 5'(`LVP_VOL_RST >> `LVP_RIGHT_LO);
      s_q.atten_left  <= 5'(`LVP_VOL_RST >> `LVP_LEFT_LO);
      s_q.pwr         <= `LVP_PWR_RST;
      s_q.pwr_out     <= `LVP_PWR_RST;
      s_q.waitreq     <= 1'b1;
      s_q.rdata       <= 32'h0000_0000;
      s_q.resp        <= `LVP_RESP_OK;
      s_q.ramp_cnt    <= 24'h00_0000;
      s_q.ramp_busy   <= 1'b0;
      s_q.ramp_up     <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign avs_readdata         = s_q.rdata;
  assign avs_waitrequest      = s_q.waitreq;
  assign avs_response         = s_q.resp;
  assign lineout_atten_right  = s_q.atten_right;
  assign lineout_atten_left   = s_q.atten_left;
  assign dac_mono_n_stereo    = s_q.pwr_out[`LVP_B_DAC_MONO];
  assign core_reg_simple_on   = s_q.pwr_out[`LVP_B_SIMPLE];
  assign startup_circuit_on   = s_q.pwr_out[`LVP_B_STARTUP];
  assign charge_pump_on       = s_q.pwr_out[`LVP_B_CHGPMP];
  assign pll_on               = s_q.pwr_out[`LVP_B_PLL];
  assign core_reg_primary_on  = s_q.pwr_out[`LVP_B_PRIMARY];
  assign osc_amp_on           = s_q.pwr_out[`LVP_B_OSCAMP];
  assign ground_ref_buffer_on = s_q.pwr_out[`LVP_B_GREF];
  assign adc_stereo           = s_q.pwr_out[`LVP_B_ADC_MONO];
  assign ref_bias_current_on  = s_q.pwr_out[`LVP_B_REFBIAS];
  assign headphone_on         = s_q.pwr_out[`LVP_B_HP];
  assign dac_on               = s_q.pwr_out[`LVP_B_DAC];
  assign capless_hp_on        = s_q.pwr_out[`LVP_B_CAPLESS];
  assign adc_on               = s_q.pwr_out[`LVP_B_ADC];
  assign line_driver_on       = s_q.pwr_out[`LVP_B_LINE];
  assign ramp_busy            = s_q.ramp_busy;

  // Helper: a write ending this cycle
  logic wr_end;
  assign wr_end = avs_write && !avs_waitrequest;

  property p_vol_right;
    @(posedge core_clk) disable iff (!nrst)
      wr_end && hit_vol && avs_byteenable[1]
      |=> lineout_atten_right == $past(avs_writedata[`LVP_RIGHT_HI:`LVP_RIGHT_LO]);
  endproperty
  a_vol_right: assert property (p_vol_right)
    else $error("right volume not stored");

  property p_vol_left;
    @(posedge core_clk) disable iff (!nrst)
      wr_end && hit_vol && avs_byteenable[0]
      |=> lineout_atten_left == $past(avs_writedata[`LVP_LEFT_HI:`LVP_LEFT_LO]);
  endproperty
  a_vol_left: assert property (p_vol_left)
    else $error("left volume not stored");

  property p_vol_rsvd;
    @(posedge core_clk) disable iff (!nrst)
      avs_read && !avs_waitrequest && hit_vol
      |-> (avs_readdata & ~{16'h0000, `LVP_VOL_MASK}) == 32'h0000_0000;
  endproperty
  a_vol_rsvd: assert property (p_vol_rsvd)
    else $error("reserved volume bits not zero");

  property p_pll;
    @(posedge core_clk) disable iff (!nrst)
      wr_end && hit_pwr && avs_byteenable[1]
      |=> pll_on == $past(avs_writedata[`LVP_B_PLL]) &&
          core_reg_primary_on == $past(avs_writedata[`LVP_B_PRIMARY]);
  endproperty
  a_pll: assert property (p_pll)
    else $error("pll or primary regulator not stored");

  property p_hi_bits;
    @(posedge core_clk) disable iff (!nrst)
      wr_end && hit_pwr && avs_byteenable[1]
      |=> dac_mono_n_stereo == $past(avs_writedata[`LVP_B_DAC_MONO]) &&
          core_reg_simple_on == $past(avs_writedata[`LVP_B_SIMPLE]) &&
          startup_circuit_on == $past(avs_writedata[`LVP_B_STARTUP]);
  endproperty
  a_hi_bits: assert property (p_hi_bits)
    else $error("upper power bits not stored");

  property p_lo_bits;
    @(posedge core_clk) disable iff (!nrst)
      wr_end && hit_pwr && avs_byteenable[0]
      |=> ground_ref_buffer_on == $past(avs_writedata[`LVP_B_GREF]) &&
          adc_stereo == $past(avs_writedata[`LVP_B_ADC_MONO]) &&
          ref_bias_current_on == $past(avs_writedata[`LVP_B_REFBIAS]);
  endproperty
  a_lo_bits: assert property (p_lo_bits)
    else $error("lower power bits not stored");

  property p_pwr_read;
    @(posedge core_clk) disable iff (!nrst)
      avs_read && !avs_waitrequest && hit_pwr
      |-> avs_readdata[15:0] == s_q.pwr;
  endproperty
  a_pwr_read: assert property (p_pwr_read)
    else $error("power register read mismatch");

  property p_hold;
    @(posedge core_clk) disable iff (!nrst)
      $fell(ground_ref_buffer_on) && $past(line_driver_on)
      |-> line_driver_on [*8];
  endproperty
  a_hold: assert property (p_hold)
    else $error("line driver dropped during ramp-down");

  property p_answer;
    @(posedge core_clk) disable iff (!nrst)
      req && avs_waitrequest |-> ##[1:2] !avs_waitrequest;
  endproperty
  a_answer: assert property (p_answer)
    else $error("bus request not answered");

  property p_wait_one;
    @(posedge core_clk) disable iff (!nrst)
      !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("waitrequest low for more than one cycle");

  property p_decerr;
    @(posedge core_clk) disable iff (!nrst)
      req && avs_waitrequest && !hit_vol && !hit_pwr && !hit_sts
      |=> avs_response == `LVP_RESP_DECERR && avs_readdata == 32'h0000_0000;
  endproperty
  a_decerr: assert property (p_decerr)
    else $error("unmapped access not refused");

  property p_vol_keep;
    @(posedge core_clk) disable iff (!nrst)
      !(wr_end && hit_vol)
      |=> $stable(lineout_atten_right) && $stable(lineout_atten_left);
  endproperty
  a_vol_keep: assert property (p_vol_keep)
    else $error("volume changed without a volume write");

  property p_rsvd_pwr;
    @(posedge core_clk) disable iff (!nrst)
      wr_end && hit_pwr && avs_byteenable[1]
      |=> s_q.pwr[`LVP_B_RSVD] == $past(avs_writedata[`LVP_B_RSVD]);
  endproperty
  a_rsvd_pwr: assert property (p_rsvd_pwr)
    else $error("power bit 15 not stored");

  property p_ramp_start;
    @(posedge core_clk) disable iff (!nrst)
      wr_end && hit_pwr && avs_byteenable[0] &&
      avs_writedata[`LVP_B_GREF] != ground_ref_buffer_on
      |=> ramp_busy && ground_ref_buffer_on == $past(avs_writedata[`LVP_B_GREF]);
  endproperty
  a_ramp_start: assert property (p_ramp_start)
    else $error("ground buffer change did not start a ramp");

  property p_drv_free;
    @(posedge core_clk) disable iff (!nrst)
      !ramp_busy
      |-> {headphone_on, capless_hp_on, line_driver_on} ==
          {s_q.pwr[`LVP_B_HP], s_q.pwr[`LVP_B_CAPLESS], s_q.pwr[`LVP_B_LINE]};
  endproperty
  a_drv_free: assert property (p_drv_free)
    else $error("amplifier enable held after the ramp ended");

  c_vol_wr: cover property (@(posedge core_clk) wr_end && hit_vol);
  c_pwr_wr: cover property (@(posedge core_clk) wr_end && hit_pwr);
  c_ramp_dn: cover property (@(posedge core_clk)
    $fell(ground_ref_buffer_on));
  c_ramp_up: cover property (@(posedge core_clk) $rose(ground_ref_buffer_on));
  c_decerr: cover property (@(posedge core_clk)
    !avs_waitrequest && avs_response == `LVP_RESP_DECERR);

endmodule // lvp_regs
`default_nettype wire

// ===== tb/tb_lvp_regs.sv
// Purpose: Self-checking bench for the line-out volume and power register bank
// Assumes: Word-addressed slave, short ramp, external core supply, 3.3 V supplies
// Notes:   Bus tasks hold each request until waitrequest is sampled low
`timescale 1ns/1ps
`default_nettype none
`include "lvp_defs.svh"
module tb_lvp_regs;
  localparam logic [7:0] A_VOL = {2'b00, `LVP_IDX_VOL};
  localparam logic [7:0] A_PWR = {2'b00, `LVP_IDX_PWR};
  localparam logic [7:0] A_STS = {2'b00, `LVP_IDX_STS};
  localparam logic [7:0] A_BAD = 8'h10;
  logic        core_clk = 1'b0;
  logic        nrst = 1'b0;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [1:0]  avs_response;
  logic [4:0]  lineout_atten_right;
  logic [4:0]  lineout_atten_left;
  logic        dac_mono_n_stereo, core_reg_simple_on, startup_circuit_on, charge_pump_on;
  logic        pll_on, core_reg_primary_on, osc_amp_on, ground_ref_buffer_on, adc_stereo;
  logic        ref_bias_current_on, headphone_on, dac_on, capless_hp_on, adc_on;
  logic        line_driver_on, ramp_busy;
  logic [31:0] rd;
  logic [1:0]  rsp;
  int          failures = 0;
  int          total_checks = 0;

  always #20 core_clk = ~core_clk;

  lvp_regs #(.RAMP_CYC(20)) dut (
    .core_clk(core_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response), .lineout_atten_right(lineout_atten_right),
    .lineout_atten_left(lineout_atten_left), .dac_mono_n_stereo(dac_mono_n_stereo),
    .core_reg_simple_on(core_reg_simple_on), .startup_circuit_on(startup_circuit_on),
    .charge_pump_on(charge_pump_on), .pll_on(pll_on),
    .core_reg_primary_on(core_reg_primary_on), .osc_amp_on(osc_amp_on),
    .ground_ref_buffer_on(ground_ref_buffer_on), .adc_stereo(adc_stereo),
    .ref_bias_current_on(ref_bias_current_on), .headphone_on(headphone_on),
    .dac_on(dac_on), .capless_hp_on(capless_hp_on), .adc_on(adc_on),
    .line_driver_on(line_driver_on), .ramp_busy(ramp_busy));

  function automatic logic [14:0] outs();
    return {dac_mono_n_stereo, core_reg_simple_on, startup_circuit_on, charge_pump_on,
            pll_on, core_reg_primary_on, osc_amp_on, ground_ref_buffer_on, adc_stereo,
            ref_bias_current_on, headphone_on, dac_on, capless_hp_on, adc_on,
            line_driver_on};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One bus cycle; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] d,
                     input logic [3:0] be);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= {16'h0000, d};
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    rsp = avs_response;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic wait_idle();
    int n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (ramp_busy !== 1'b0 && n < 100);
    if (n >= 100) failures++;
  endtask

  task automatic t_reset();
    bus(1'b0, A_VOL, 16'h0000, 4'hF);
    chk(rd, {16'h0, `LVP_VOL_RST});
    chk({30'h0, rsp}, {30'h0, `LVP_RESP_OK});
    chk({22'h0, lineout_atten_right, lineout_atten_left}, 32'h84);
    bus(1'b0, A_PWR, 16'h0000, 4'hF);
    chk(rd, {16'h0, `LVP_PWR_RST});
    chk({17'h0, outs()}, {17'h0, `LVP_PWR_RST} & 32'h7FFF);
  endtask

  task automatic t_volume();
    bus(1'b1, A_VOL, 16'hFFFF, 4'hF);
    bus(1'b0, A_VOL, 16'h0000, 4'hF);
    chk(rd, {16'h0, `LVP_VOL_MASK});
    bus(1'b1, A_VOL, 16'h0000, 4'h1);
    bus(1'b0, A_VOL, 16'h0000, 4'hF);
    chk(rd, 32'h1F00);
    chk({22'h0, lineout_atten_right, lineout_atten_left}, 32'h3E0);
    bus(1'b1, A_VOL, 16'h0F0F, 4'hF);
    bus(1'b0, A_VOL, 16'h0000, 4'hF);
    chk({22'h0, lineout_atten_right, lineout_atten_left}, 32'h1EF);
    bus(1'b1, A_VOL, 16'h0A13, 4'hF);
    bus(1'b0, A_VOL, 16'h0000, 4'hF);
    chk({22'h0, lineout_atten_right, lineout_atten_left}, 32'h153);
  endtask

  task automatic t_power();
    logic [15:0] d;
    for (int i = 0; i < 16; i++) begin
      d = 16'h0001 << i;
      if (i == `LVP_B_CHGPMP) begin
        // Pump only with the PLL set up and powered
        d[`LVP_B_PLL] = 1'b1;
      end
      bus(1'b1, A_PWR, d, 4'hF);
      bus(1'b0, A_PWR, 16'h0000, 4'hF);
      chk(rd, {16'h0, d});
      chk({17'h0, outs()}, {17'h0, d[14:0]});
    end
  endtask

  task automatic t_ramp();
    wait_idle();
    bus(1'b1, A_PWR, 16'h0015, 4'hF);
    bus(1'b1, A_PWR, 16'h0095, 4'hF);
    bus(1'b0, A_STS, 16'h0000, 4'hF);
    chk(rd & 32'h3, 32'h3);
    wait_idle();
    bus(1'b1, A_PWR, 16'h0000, 4'hF);
    bus(1'b0, A_STS, 16'h0000, 4'hF);
    chk(rd & 32'h3, 32'h1);
    chk({17'h0, outs()}, 32'h15);
    wait_idle();
    bus(1'b0, A_PWR, 16'h0000, 4'hF);
    chk({17'h0, outs()}, 32'h0);
  endtask

  task automatic t_unmapped();
    bus(1'b0, A_BAD, 16'h0000, 4'hF);
    chk(rd, 32'h0);
    chk({30'h0, rsp}, {30'h0, `LVP_RESP_DECERR});
    bus(1'b1, A_BAD, 16'hFFFF, 4'hF);
    bus(1'b0, A_VOL, 16'h0000, 4'hF);
    chk(rd, 32'h0A13);
  endtask

  task automatic print_verdict();
    if (failures == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge core_clk);
    nrst <= 1'b1;
    t_reset();
    t_volume();
    t_power();
    t_ramp();
    t_unmapped();
    print_verdict();
  end

  initial begin
    repeat (5000) @(posedge core_clk);
    failures++;
    print_verdict();
  end
endmodule // tb_lvp_regs
`default_nettype wire
